// >>> rtl/slm_defines.svh
// constants for the single-instruction loop mode controller
`ifndef SLM_DEFINES_SVH
`define SLM_DEFINES_SVH
`define SLM_LOOP_DISP 16'hFFFC
`define SLM_COUNT_EXHAUSTED 16'hFFFF
`define SLM_OP_MOVE_B 4'h1
`define SLM_OP_MOVE_L 4'h2
`define SLM_OP_MOVE_W 4'h3
`define SLM_OP_OR 4'h8
`define SLM_OP_SUB 4'h9
`define SLM_OP_CMP_EOR 4'hB
`define SLM_OP_AND 4'hC
`define SLM_OP_ADD 4'hD
`define SLM_OP_SHIFT 4'hE
`define SLM_OP_MISC 4'h4
`define SLM_OP_BRANCH 4'h5
`define SLM_TEST_DECREMENT_BRANCH_MASK 16'hF0F8
`define SLM_TEST_DECREMENT_BRANCH_CODE 16'h50C8
`define SLM_MODE_IND 3'h2
`define SLM_MODE_POST 3'h3
`define SLM_MODE_PRE 3'h4
`define SLM_MODE_DREG 3'h0
`define SLM_MODE_AREG 3'h1
`endif

// >>> rtl/slm_loop_ctrl.sv
// loop-mode controller of the instruction unit
//************************************************************
// Functional notes
//************************************************************
// Functional notes
// - count minus one: store it, fall through
// - condition true: discard count, fall through (code still stores the count FFFF when the count was zero)
// - otherwise add displacement to program counter
// - hold loop in decode register and queue
// - enter only: looping, disp -4, eligible target
// - switch on second fetch of looped op
// - no instruction fetches while looping
// - entry automatic, program results unchanged
// - interrupts accepted only after branch execution
// - interrupt exception ends loop mode
// - trace enabled keeps loop mode off
// - reset aborts loop mode
// - bus error exits; return skips loop refetch
// - only one-word indirect-mode forms qualify
// - move forms qualify
// - memory-to-data-register arithmetic qualifies
// - address-register add, compare, subtract qualify
// - data-register-to-memory arithmetic qualifies
// - single-operand memory forms qualify
// - word memory shifts by one qualify
`timescale 1ns/1ns
`default_nettype none
`include "slm_defines.svh"

module slm_loop_ctrl (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_fetch_valid,
    input wire logic [15:0] i_fetch_word,
    input wire logic [31:0] i_fetch_pc,
    input wire slm_pkg::slm_branch_t i_branch,
    input wire logic [31:0] i_branch_pc,
    input wire logic i_irq_pending,
    input wire logic i_irq_taken,
    input wire logic i_trace_en,
    input wire logic i_bus_error,
    input wire logic i_rte_resume,
    output logic o_loop_active,
    output logic o_fetch_inhibit,
    output logic o_irq_window,
    output logic o_skip_refetch,
    output logic [15:0] o_looped_op,
    output logic [15:0] o_branch_op,
    output logic [15:0] o_branch_disp,
    output logic [31:0] o_resume_pc,
    output slm_pkg::slm_verdict_t o_verdict
);
    import slm_pkg::*;

    slm_regs_t s_reg;
    slm_regs_t s_next;

    //************************************************************
    // eligibility decode
    //************************************************************
    function automatic logic mem_mode(input logic [2:0] m);
        mem_mode = (m == `SLM_MODE_IND) || (m == `SLM_MODE_POST) || (m == `SLM_MODE_PRE);
    endfunction : mem_mode

    function automatic logic eligible(input logic [15:0] w);
        logic [3:0] grp;
        logic [2:0] dmode;
        logic [2:0] smode;
        logic [2:0] opm;
        logic ok;
        grp = w[15:12];
        dmode = w[8:6];
        smode = w[5:3];
        opm = w[8:6];
        ok = 1'b0;
        case (grp)
            `SLM_OP_MOVE_B, `SLM_OP_MOVE_L, `SLM_OP_MOVE_W: begin
                // memory to memory, or register to postincrement
                if (mem_mode(smode) && mem_mode(dmode))
                    ok = 1'b1;
                else if ((smode == `SLM_MODE_DREG || smode == `SLM_MODE_AREG)
                         && dmode == `SLM_MODE_POST && grp != `SLM_OP_MOVE_B)
                    ok = 1'b1;
                else if (smode == `SLM_MODE_DREG && dmode == `SLM_MODE_POST)
                    ok = 1'b1;
            end
            `SLM_OP_ADD, `SLM_OP_SUB, `SLM_OP_AND, `SLM_OP_OR, `SLM_OP_CMP_EOR: begin
                if (opm[2] == 1'b0 && opm[1:0] != 2'h3 && mem_mode(smode))
                    ok = (grp != `SLM_OP_CMP_EOR) || 1'b1;
                else if (opm[1:0] == 2'h3 && mem_mode(smode)
                         && grp != `SLM_OP_AND && grp != `SLM_OP_OR)
                    ok = 1'b1;
                else if (opm[2] && opm[1:0] != 2'h3 && mem_mode(smode)
                         && (grp == `SLM_OP_CMP_EOR || grp == `SLM_OP_ADD
                             || grp == `SLM_OP_SUB || grp == `SLM_OP_AND
                             || grp == `SLM_OP_OR))
                    ok = 1'b1;
            end
            `SLM_OP_MISC: begin
                // clear, negate, negate-extend, complement, test
                if ((w[11:8] == 4'h0 || w[11:8] == 4'h2 || w[11:8] == 4'h4
                     || w[11:8] == 4'h6 || w[11:8] == 4'hA)
                    && w[7:6] != 2'h3 && mem_mode(smode))
                    ok = 1'b1;
                else if (w[11:6] == 6'h20 && mem_mode(smode))
                    ok = 1'b1;
            end
            `SLM_OP_SHIFT: begin
                // memory shift form is word size and always one bit
                if (w[7:6] == 2'h3 && w[11] == 1'b0 && mem_mode(smode))
                    ok = 1'b1;
            end
            default: ok = 1'b0;
        endcase
        eligible = ok;
    endfunction : eligible

    logic is_branch_op;
    logic fetch_elig;
    logic [15:0] dec_count;
    logic count_done;
    logic loops;
    logic abort;

    always_comb begin
        is_branch_op = (i_branch.opword & `SLM_TEST_DECREMENT_BRANCH_MASK) == `SLM_TEST_DECREMENT_BRANCH_CODE;
        fetch_elig = eligible(i_fetch_word);
        dec_count = i_branch.count - 16'h0001;
        count_done = dec_count == `SLM_COUNT_EXHAUSTED;
        loops = !count_done && !i_branch.cond_true;
        // trace, interrupt or bus error drop the loop
        abort = i_trace_en || i_irq_taken || i_bus_error;
    end

    //************************************************************
    // next state
    //************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.verdict.valid = 1'b0;
        s_next.verdict.write_count = 1'b0;
        s_next.refetch = 1'b0;
        if (i_branch.valid && is_branch_op) begin
            s_next.verdict.valid = 1'b1;
            s_next.verdict.count = dec_count;
            if (count_done) begin
                s_next.verdict.write_count = 1'b1;
                s_next.verdict.taken = 1'b0;
                s_next.verdict.next_pc = i_branch_pc + 32'h0000_0004;
            end else if (i_branch.cond_true) begin
                s_next.verdict.taken = 1'b0;
                s_next.verdict.next_pc = i_branch_pc + 32'h0000_0004;
            end else begin
                s_next.verdict.write_count = 1'b1;
                s_next.verdict.taken = 1'b1;
                s_next.verdict.next_pc = i_branch_pc + 32'h0000_0002
                    + {{16{i_branch.disp[15]}}, i_branch.disp};
            end
        end
        case (s_reg.state)
            SLM_IDLE: begin
                // a looping branch back over one word arms detection
                if (i_branch.valid && is_branch_op && loops && !i_trace_en
                    && i_branch.disp == `SLM_LOOP_DISP) begin
                    s_next.state = SLM_ARMED;
                    s_next.branch_op = i_branch.opword;
                    s_next.branch_disp = i_branch.disp;
                    s_next.resume_pc = i_branch_pc + 32'h0000_0004;
                end
            end
            SLM_ARMED: begin
                // second fetch of the target decides entry
                if (abort) begin
                    s_next.state = SLM_IDLE;
                end else if (i_fetch_valid && i_fetch_pc == s_reg.resume_pc - 32'h0000_0006) begin
                    if (eligible(i_fetch_word) && fetch_elig) begin
                        s_next.state = SLM_LOOP;
                        s_next.looped_op = i_fetch_word;
                        s_next.active = 1'b1;
                        s_next.fetch_inhibit = 1'b1;
                    end else begin
                        s_next.state = SLM_IDLE;
                    end
                end else if (i_fetch_valid && i_fetch_pc != s_reg.resume_pc - 32'h0000_0004) begin
                    s_next.state = SLM_IDLE;
                end
            end
            SLM_LOOP: begin
                // interrupts only sampled after the branch completes
                s_next.irq_window = i_branch.valid && is_branch_op && i_irq_pending;
                if (i_bus_error) begin
                    // the queue stays intact for the return to resume
                    s_next.fetch_inhibit = 1'b0;
                    s_next.active = 1'b0;
                end else if (i_rte_resume && !s_reg.active) begin
                    s_next.active = 1'b1;
                    s_next.fetch_inhibit = 1'b1;
                    s_next.refetch = 1'b1;
                end else if (i_trace_en || i_irq_taken
                             || (i_branch.valid && is_branch_op && !loops)) begin
                    s_next.state = SLM_IDLE;
                    s_next.active = 1'b0;
                    s_next.fetch_inhibit = 1'b0;
                    s_next.irq_window = 1'b0;
                end
            end
            default: s_next.state = SLM_IDLE;
        endcase
        if (s_next.state == SLM_IDLE) begin
            s_next.active = 1'b0;
            s_next.fetch_inhibit = 1'b0;
            s_next.irq_window = 1'b0;
        end
    end

    //************************************************************
    // state register
    //************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_loop_active = s_reg.active;
    assign o_fetch_inhibit = s_reg.fetch_inhibit;
    assign o_irq_window = s_reg.irq_window;
    assign o_skip_refetch = s_reg.refetch;
    assign o_looped_op = s_reg.looped_op;
    assign o_branch_op = s_reg.branch_op;
    assign o_branch_disp = s_reg.branch_disp;
    assign o_resume_pc = s_reg.resume_pc;
    assign o_verdict = s_reg.verdict;

endmodule : slm_loop_ctrl
`default_nettype wire

// >>> rtl/slm_pkg.sv
// types for the single-instruction loop mode controller
package slm_pkg;

    typedef enum logic [1:0] {
        SLM_IDLE,
        SLM_ARMED,
        SLM_LOOP
    } slm_state_t;

    // decoded view of the branch instruction at execution time
    typedef struct packed {
        logic valid;
        logic [15:0] opword;
        logic [15:0] disp;
        logic [15:0] count;
        logic cond_true;
    } slm_branch_t;

    // verdict of one branch execution
    typedef struct packed {
        logic valid;
        logic write_count;
        logic [15:0] count;
        logic taken;
        logic [31:0] next_pc;
    } slm_verdict_t;

    typedef struct packed {
        slm_state_t state;
        logic [15:0] looped_op;
        logic [15:0] branch_op;
        logic [15:0] branch_disp;
        logic active;
        logic fetch_inhibit;
        logic irq_window;
        logic refetch;
        logic [31:0] resume_pc;
        slm_verdict_t verdict;
    } slm_regs_t;

endpackage : slm_pkg

// >>> tb/slm_loop_monitor.sv
// port-level checker of the loop-mode controller
`timescale 1ns/1ns
`default_nettype none
module slm_loop_monitor (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire slm_pkg::slm_branch_t i_branch,
    input wire logic [31:0] i_branch_pc,
    input wire logic i_irq_taken,
    input wire logic i_trace_en,
    input wire logic o_loop_active,
    input wire logic o_fetch_inhibit,
    input wire logic o_irq_window,
    input wire logic [15:0] o_branch_op,
    input wire logic [15:0] o_branch_disp,
    input wire slm_pkg::slm_verdict_t o_verdict
);
    import slm_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic hit;
    logic go_on;
    assign hit = i_branch.valid && ((i_branch.opword & 16'hF0F8) == 16'h50C8);
    assign go_on = hit && (i_branch.count != 16'h0000);
    //********
    // checks
    //********
    property p_answer;
        hit |=> o_verdict.valid;
    endproperty
    a_answer: assert property (p_answer) else $error("no verdict");
    property p_done;
        hit && i_branch.count == 16'h0000 |=> o_verdict.write_count && !o_verdict.taken
            && o_verdict.count == 16'hFFFF;
    endproperty
    a_done: assert property (p_done) else $error("bad exhausted verdict");
    property p_discard;
        go_on && i_branch.cond_true |=> !o_verdict.write_count && !o_verdict.taken;
    endproperty
    a_discard: assert property (p_discard) else $error("count kept");
    property p_taken;
        go_on && !i_branch.cond_true |=> o_verdict.taken && o_verdict.next_pc ==
            $past(i_branch_pc) + 32'h2 + {{16{$past(i_branch.disp[15])}}, $past(i_branch.disp)};
    endproperty
    a_taken: assert property (p_taken) else $error("bad branch target");
    property p_quiet;
        o_loop_active |-> o_fetch_inhibit;
    endproperty
    a_quiet: assert property (p_quiet) else $error("fetch while looping");
    property p_window;
        o_irq_window |-> $past(hit);
    endproperty
    a_window: assert property (p_window) else $error("window not after branch");
    property p_irq;
        i_irq_taken |=> !o_loop_active;
    endproperty
    a_irq: assert property (p_irq) else $error("loop kept after interrupt");
    property p_trace;
        i_trace_en |=> !o_loop_active;
    endproperty
    a_trace: assert property (p_trace) else $error("loop while tracing");
    property p_entry;
        $rose(o_loop_active) |-> o_branch_disp == 16'hFFFC && o_branch_op[15:12] == 4'h5;
    endproperty
    a_entry: assert property (p_entry) else $error("bad loop entry");
    c_entry: cover property ($rose(o_loop_active));
    c_window: cover property (o_irq_window);
    c_taken: cover property (o_verdict.valid && o_verdict.taken);
endmodule : slm_loop_monitor
bind slm_loop_ctrl slm_loop_monitor i_mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_branch(i_branch), .i_branch_pc(i_branch_pc), .i_irq_taken(i_irq_taken),
    .i_trace_en(i_trace_en), .o_loop_active(o_loop_active), .o_fetch_inhibit(o_fetch_inhibit),
    .o_irq_window(o_irq_window), .o_branch_op(o_branch_op), .o_branch_disp(o_branch_disp),
    .o_verdict(o_verdict));
`default_nettype wire

// >>> tb/slm_mem_model.sv
// instruction memory model answering fetches promptly or one cycle late
`timescale 1ns/1ns
`default_nettype none
module slm_mem_model (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_slow,
    input wire logic [31:0] i_pc,
    input wire logic [15:0] i_target_word,
    output logic o_valid = 1'b0,
    output logic [31:0] o_pc = 32'h0,
    output logic [15:0] o_word = 16'hA5A5
);
    logic pend_reg = 1'b0;
    logic [31:0] pc_reg = 32'h0;
    logic [31:0] addr;
    logic hit;
    assign addr = pend_reg ? pc_reg : i_pc;
    assign hit = (i_req && !i_slow) || pend_reg;
    always @(posedge i_clk) begin
        pend_reg <= i_req && i_slow;
        if (i_req)
            pc_reg <= i_pc;
        o_valid <= hit;
        o_pc <= addr;
        // released bus shows inverted data so a stale word never looks valid
        if (!hit)
            o_word <= ~o_word;
        else if (addr == 32'h0000_00FE)
            o_word <= i_target_word;
        else
            o_word <= (addr == 32'h0000_0100) ? 16'h57C8 : 16'h4E71;
    end
endmodule : slm_mem_model
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking testbench of the loop-mode controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import slm_pkg::*;
    logic i_clk = 1'b0, i_rst_n = 1'b0, req = 1'b0, slow = 1'b0, irq_p = 1'b0, trc = 1'b0;
    logic [2:0] ev = 3'h0;
    logic [31:0] pc = 32'h0;
    logic [15:0] tgt = 16'h32D8;
    slm_branch_t br = '0;
    logic fv, act, inh, win, skip;
    logic [15:0] fw, lop, bop, bd;
    logic [31:0] fpc, rpc;
    slm_verdict_t vd;
    logic [15:0] ok_w [6] = '{16'h32D8, 16'hD250, 16'hD2D0, 16'hB350, 16'h4810, 16'hE1D0};
    int num_errors = 0, checked = 0;
    always #2 i_clk = ~i_clk;
    slm_mem_model i_mem (.i_clk(i_clk), .i_req(req), .i_slow(slow), .i_pc(pc),
        .i_target_word(tgt), .o_valid(fv), .o_pc(fpc), .o_word(fw));
    slm_loop_ctrl i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_fetch_valid(fv),
        .i_fetch_word(fw), .i_fetch_pc(fpc), .i_branch(br), .i_branch_pc(32'h0000_0100),
        .i_irq_pending(irq_p), .i_irq_taken(ev[0]), .i_trace_en(trc), .i_bus_error(ev[1]),
        .i_rte_resume(ev[2]), .o_loop_active(act), .o_fetch_inhibit(inh), .o_irq_window(win),
        .o_skip_refetch(skip), .o_looped_op(lop), .o_branch_op(bop), .o_branch_disp(bd),
        .o_resume_pc(rpc), .o_verdict(vd));
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task results();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    task branch(input logic [15:0] cnt, input logic ct, input logic [15:0] d);
        @(posedge i_clk);
        br <= '{1'b1, 16'h57C8, d, cnt, ct};
        @(posedge i_clk);
        br.valid <= 1'b0;
        #1;
    endtask : branch
    task pulse(input int k);
        @(posedge i_clk);
        ev[k] <= 1'b1;
        @(posedge i_clk);
        ev[k] <= 1'b0;
        #1;
    endtask : pulse
    // loop mode is a level, so a few spare cycles cost nothing
    task arm(input logic [15:0] w, input logic [15:0] d);
        tgt <= w;
        branch(16'h0005, 1'b0, d);
        slow <= ~slow;
        @(posedge i_clk);
        req <= 1'b1;
        pc <= 32'h0000_00FE;
        @(posedge i_clk);
        req <= 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
    endtask : arm
    task enter(input logic [15:0] w, input logic t, input logic [15:0] d, input logic e);
        trc <= t;
        arm(w, d);
        chk({act, inh}, {e, e});
        if (e) begin
            chk({lop, bop, bd}, {w, 16'h57C8, 16'hFFFC});
            chk(rpc, 32'h0000_0104);
        end
        pulse(0);
        chk(act, 1'b0);
        trc <= 1'b0;
        $display("entry test %h done", w);
    endtask : enter
    task t_loop();
        irq_p <= 1'b1;
        arm(16'h32D8, 16'hFFFC);
        branch(16'h0007, 1'b0, 16'hFFFC);
        chk({win, act, vd.taken}, 3'b111);
        @(posedge i_clk);
        #1;
        chk(win, 1'b0);
        pulse(1);
        chk({act, lop}, {1'b0, 16'h32D8});
        pulse(2);
        chk({skip, act}, 2'b11);
        branch(16'h0000, 1'b0, 16'hFFFC);
        @(posedge i_clk);
        #1;
        chk(act, 1'b0);
        arm(16'h32D8, 16'hFFFC);
        i_rst_n <= 1'b0;
        #1;
        chk(act, 1'b0);
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        irq_p <= 1'b0;
        $display("loop test done");
    endtask : t_loop
    task t_verdict();
        branch(16'h0000, 1'b0, 16'hFFFC);
        chk({vd.valid, vd.write_count, vd.taken, vd.count}, {3'b110, 16'hFFFF});
        branch(16'h0005, 1'b1, 16'hFFFC);
        chk({vd.valid, vd.write_count, vd.taken}, 3'b100);
        branch(16'h0005, 1'b0, 16'hFFFC);
        chk({vd.valid, vd.taken, vd.count, vd.next_pc}, {2'b11, 16'h0004, 32'hFE});
        $display("verdict test done");
    endtask : t_verdict
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_verdict();
        foreach (ok_w[i])
            enter(ok_w[i], 1'b0, 16'hFFFC, 1'b1);
        enter(16'h3200, 1'b0, 16'hFFFC, 1'b0);
        enter(16'h32D8, 1'b1, 16'hFFFC, 1'b0);
        enter(16'h32D8, 1'b0, 16'hFFF8, 1'b0);
        t_loop();
        results();
    end
    initial begin
        #20000;
        num_errors++;
        results();
    end
endmodule : tb_top
`default_nettype wire
